// ### hw/sirm_top.sv
// supply integrity reset monitor: reset pin drive, warning detector, status register
`timescale 1ns/1ps
// ----------------------------------------
// ----------------------------------------
module sirm_top
  import sirm_pkg::*;
#(
  parameter int DELAY_LONG_CYC = DELAY_LONG
) (
  input wire logic clk,
  input wire logic nrst,
  // avalon-mm slave
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // analog comparator outputs, asynchronous
  input wire logic uv_cmp,
  input wire logic warn_supply_cmp,
  input wire logic warn_pin_cmp,
  // watchdog underflow pulse, same clock
  input wire logic dog_underflow,
  // option byte
  input wire sirm_opt_t opt,
  // cpu power modes and interrupt handshake
  input wire logic halt_mode,
  input wire logic wait_mode,
  input wire logic irq_enter,
  // reset pin, open drain
  input wire logic rst_pin_in,
  output logic rst_pin_out,
  output logic rst_pin_oe,
  // outputs
  output sirm_thr_t warn_thr,
  output logic warn_irq,
  output logic wake_req,
  output logic sys_rst_n
);

  // ----------------------------------------
  // synchronisers
  // ----------------------------------------
  logic [2:0] meta_q; // first stage, read only by second
  logic [2:0] sync_q; // second stage
  logic pin_meta_q;
  logic pin_sync_q;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      meta_q <= 3'h0;
      sync_q <= 3'h0;
      pin_meta_q <= 1'b1;
      pin_sync_q <= 1'b1;
    end else begin
      meta_q <= {warn_pin_cmp, warn_supply_cmp, uv_cmp};
      sync_q <= meta_q;
      pin_meta_q <= rst_pin_in;
      pin_sync_q <= pin_meta_q;
    end
  end

  logic uv_low;
  // undervolt detector only when optioned in
  assign uv_low = sync_q[0] & opt.uv_enable;

  assign warn_thr = opt.thr;

  // ----------------------------------------
  // reset pin and reset delay
  // ----------------------------------------
  logic [15:0] pulse_q; // watchdog pulse remaining
  logic [15:0] delay_q; // post-reset delay remaining
  logic pin_low;

  // watchdog pulse at least minimum width
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pulse_q <= 16'h0000;
    end else if (dog_underflow) begin
      pulse_q <= 16'(RST_PULSE_CYC);
    end else if (pulse_q != 16'h0000) begin
      pulse_q <= pulse_q - 16'h0001;
    end
  end

  // undervolt drives pin low as long as it lasts
  assign pin_low = uv_low | (pulse_q != 16'h0000);
  assign rst_pin_out = 1'b0;
  assign rst_pin_oe = pin_low;

  // delay restarts whenever the pin is low, from either source
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      delay_q <= 16'h0000;
    end else if (pin_low || !pin_sync_q) begin
      delay_q <= opt.long_delay ? 16'(DELAY_LONG_CYC) : 16'(DELAY_SHORT);
    end else if (delay_q != 16'h0000) begin
      delay_q <= delay_q - 16'h0001;
    end
  end

  logic in_reset;
  assign in_reset = pin_low | !pin_sync_q | (delay_q != 16'h0000);
  assign sys_rst_n = !in_reset;

  // ----------------------------------------
  // warning flag and register
  // ----------------------------------------
  logic src_sel_q; // 0 supply, 1 pin
  logic irq_en_q;
  logic uv_rf_q;
  logic dog_rf_q;
  logic warn_q; // register view of the comparator
  logic cpu_mask_q; // mirror of cpu global mask
  logic pend_q;
  logic warn_raw;
  logic wr_csr;
  logic wr_ctrl;

  assign wr_csr = avs_write && avs_address == REG_CSR_ADDR;
  assign wr_ctrl = avs_write && avs_address == REG_CTRL_ADDR;

  assign warn_raw = opt.uv_enable & (src_sel_q ? sync_q[2] : sync_q[1]);

  // flag tracks comparator; frozen in halt
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      warn_q <= 1'b0;
    end else if (!halt_mode) begin
      warn_q <= warn_raw;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      src_sel_q <= CSR_RESET[BIT_SRC_SEL];
      irq_en_q <= CSR_RESET[BIT_IRQ_EN];
    end else if (in_reset) begin
      src_sel_q <= CSR_RESET[BIT_SRC_SEL];
      irq_en_q <= CSR_RESET[BIT_IRQ_EN];
    end else if (wr_csr && !halt_mode) begin
      src_sel_q <= avs_writedata[BIT_SRC_SEL];
      irq_en_q <= avs_writedata[BIT_IRQ_EN];
    end
  end

  // undervolt flag, only sw zero clears; set wins
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      uv_rf_q <= CSR_RESET[BIT_UV_RF];
    end else if (uv_low) begin
      uv_rf_q <= 1'b1;
    end else if (wr_csr && !halt_mode && !avs_writedata[BIT_UV_RF]) begin
      uv_rf_q <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      dog_rf_q <= CSR_RESET[BIT_DOG_RF];
    end else if (uv_low) begin
      dog_rf_q <= 1'b0;
    end else if (dog_underflow) begin
      dog_rf_q <= 1'b1;
    end else if (wr_csr && !halt_mode && !avs_writedata[BIT_DOG_RF]) begin
      dog_rf_q <= 1'b0;
    end
  end

  // cpu global mask mirror, set at reset like the cpu
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cpu_mask_q <= 1'b1;
    end else if (in_reset) begin
      cpu_mask_q <= 1'b1;
    end else if (wr_ctrl) begin
      cpu_mask_q <= avs_writedata[BIT_CPU_MASK];
    end
  end

  // ----------------------------------------
  // interrupt pending
  // ----------------------------------------
  logic rise_en;
  logic toggle;
  logic ack;
  // enabling while flag is set raises a request
  assign rise_en = wr_csr && !halt_mode && avs_writedata[BIT_IRQ_EN] && !irq_en_q && warn_q;
  // any change of the flag, both edges
  assign toggle = (warn_raw != warn_q) && !halt_mode && irq_en_q;
  assign ack = irq_enter || (wr_ctrl && avs_writedata[BIT_IRQ_ACK]);

  // cleared at entry, blocked in reset delay; set wins
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pend_q <= 1'b0;
    end else if (in_reset) begin
      pend_q <= 1'b0;
    end else if (toggle || rise_en) begin
      pend_q <= 1'b1;
    end else if (ack || !irq_en_q) begin
      pend_q <= 1'b0;
    end
  end

  assign warn_irq = pend_q & irq_en_q & !cpu_mask_q;
  // wakes from wait, never from halt
  assign wake_req = pend_q & irq_en_q & wait_mode & !halt_mode;

  // ----------------------------------------
  // avalon read path, one wait state on reads
  // ----------------------------------------
  logic [7:0] csr_view;
  assign csr_view = {src_sel_q, irq_en_q, warn_q, uv_rf_q, 3'h0, dog_rf_q};
  logic rd_done_q; // read answered, waitrequest dropped

  // read answered one cycle after request so readdata stands at the taking edge
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rd_done_q <= 1'b0;
    end else begin
      rd_done_q <= avs_read && !rd_done_q;
    end
  end

  // writes never wait; reads wait until the data register is loaded
  assign avs_waitrequest = avs_read && !rd_done_q;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read && !rd_done_q) begin
      case (avs_address)
        REG_CSR_ADDR: avs_readdata <= {24'h00_0000, csr_view};
        REG_CTRL_ADDR: avs_readdata <= {31'h0000_0000, cpu_mask_q};
        REG_IRQ_ADDR: avs_readdata <= {31'h0000_0000, pend_q};
        default: avs_readdata <= 32'h0000_0000;
      endcase
    end
  end

endmodule

// ### inc/sirm_pkg.sv
// package: constants and types for the supply integrity reset monitor
package sirm_pkg;
  // avalon word addresses (byte address = index * 4)
  localparam logic [3:0] REG_CSR_ADDR = 4'h0;
  localparam logic [3:0] REG_CTRL_ADDR = 4'h1;
  localparam logic [3:0] REG_IRQ_ADDR = 4'h2;
  // control/status bit positions
  localparam int BIT_SRC_SEL = 7;
  localparam int BIT_IRQ_EN = 6;
  localparam int BIT_WARN = 5;
  localparam int BIT_UV_RF = 4;
  localparam int BIT_DOG_RF = 0;
  localparam logic [7:0] CSR_RESET = 8'h00;
  // own control register bits
  localparam int BIT_CPU_MASK = 0;
  localparam int BIT_IRQ_ACK = 1;
  // timing
  localparam int CLK_MHZ = 100;
  localparam int RST_PULSE_NS = 20000;
  localparam int RST_PULSE_CYC = (RST_PULSE_NS * CLK_MHZ + 999) / 1000;
  localparam int DELAY_SHORT = 256;
  localparam int DELAY_LONG = 4096;
  // threshold select from the option byte
  typedef enum logic [1:0] {THR_LOW, THR_MED, THR_HIGH, THR_RSV} sirm_thr_t;
  // option byte settings
  typedef struct packed {
    logic uv_enable;
    logic long_delay;
    sirm_thr_t thr;
  } sirm_opt_t;
endpackage

// ### verif/sirm_properties.sv
// checker: port-level properties of the supply integrity reset monitor
`timescale 1ns/1ps
module sirm_checker
  import sirm_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic uv_cmp,
  input wire logic dog_underflow,
  input wire sirm_opt_t opt,
  input wire logic halt_mode,
  input wire logic wait_mode,
  input wire logic rst_pin_out,
  input wire logic rst_pin_oe,
  input wire sirm_thr_t warn_thr,
  input wire logic warn_irq,
  input wire logic wake_req
);
  // ----------------------------------------
  // properties, one clock domain
  // ----------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  a_thr_follows_opt:
    assert property (warn_thr == opt.thr) else $error("threshold not from option");
  a_uv_pin_low:
    assert property ((opt.uv_enable && uv_cmp) [*5] |-> ##[0:2] rst_pin_oe)
    else $error("pin not driven in undervolt");
  a_dog_pin_low:
    assert property (dog_underflow |-> ##[0:3] rst_pin_oe) else $error("no dog pulse");
  a_pin_open_drain:
    assert property (!rst_pin_out) else $error("pin driven high");
  a_wait_wakes:
    assert property (warn_irq && wait_mode && !halt_mode |-> wake_req) else $error("no wake");
  a_halt_no_wake:
    assert property (halt_mode |-> !wake_req) else $error("woke from halt");
  a_reserved_zero:
    assert property (avs_read && avs_address == REG_CSR_ADDR |=>
      avs_readdata[3:1] == 3'h0 && avs_readdata[31:8] == 24'h0) else $error("reserved set");
  a_never_waits:
    assert property (avs_write |-> !avs_waitrequest) else $error("write stalled");
endmodule
bind sirm_top sirm_checker u_chk (.*);

// ### verif/sirm_supply_model.sv
// model of the comparators and the shared reset pin around the monitor
`timescale 1ns/1ps
module sirm_supply_model (
  input wire logic rst_pin_oe,
  input wire logic ext_low,
  input wire logic [2:0] lvl,
  output logic rst_pin_in,
  output logic uv_cmp,
  output logic warn_supply_cmp,
  output logic warn_pin_cmp
);
  // open drain with pull-up: any party pulling low wins
  assign rst_pin_in = !(rst_pin_oe || ext_low);
  // comparators change off the clock edge, unrelated to it
  assign #3 {uv_cmp, warn_supply_cmp, warn_pin_cmp} = lvl;
endmodule

// ### verif/sirm_top_tb.sv
// self-checking bench for the supply integrity reset monitor
`timescale 1ns/1ps
module sirm_top_tb;
  import sirm_pkg::*;
  logic clk = 0, nrst = 0, rd_s = 0, wr_s = 0, dog = 0, halt = 0, wt = 0, ent = 0, xl = 0;
  logic [3:0] adr = 4'h0;
  logic [31:0] wd = 32'h0, rdata;
  logic [2:0] lvl = 3'h0;
  logic wreq, pin_in, oe, uvc, wsc, wpc, irq, wake, srn;
  logic [63:0] nt, notes[$];
  sirm_opt_t opt = '{1'b1, 1'b0, THR_MED};
  int mismatches = 0, num_checks = 0, seed = 32'hf0a92c7e, n, r;
  always #5 clk = ~clk;
  sirm_top #(.DELAY_LONG_CYC(300)) DUT (.clk(clk), .nrst(nrst), .avs_address(adr),
    .avs_read(rd_s), .avs_write(wr_s), .avs_writedata(wd), .avs_readdata(rdata),
    .avs_waitrequest(wreq), .uv_cmp(uvc), .warn_supply_cmp(wsc), .warn_pin_cmp(wpc),
    .dog_underflow(dog), .opt(opt), .halt_mode(halt), .wait_mode(wt), .irq_enter(ent),
    .rst_pin_in(pin_in), .rst_pin_out(), .rst_pin_oe(oe), .warn_thr(), .warn_irq(irq),
    .wake_req(wake), .sys_rst_n(srn));
  sirm_supply_model u_sup (.rst_pin_oe(oe), .ext_low(xl), .lvl(lvl), .rst_pin_in(pin_in),
    .uv_cmp(uvc), .warn_supply_cmp(wsc), .warn_pin_cmp(wpc));
  task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task end_of_test;
    if (mismatches == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // one avalon transfer, held until waitrequest is seen low
  task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    adr <= a; wd <= d; wr_s <= w; rd_s <= !w;
    @(posedge clk);
    while (wreq !== 1'b0) @(posedge clk);
    wr_s <= 0; rd_s <= 0;
    @(posedge clk);
  endtask
  task rd(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m);
    notes.push_back({e, m});
    bus(0, a, 32'h0);
  endtask
  task wait_run;
    n = 0;
    while (srn !== 1'b1 && n < 5000) begin @(posedge clk); n++; end
  endtask
  // read data taken at the edge where waitrequest is seen low
  always @(posedge clk) begin
    if (rd_s && wreq === 1'b0 && notes.size() > 0) begin
      nt = notes.pop_front();
      check("readdata", rdata & nt[31:0], nt[63:32]);
    end
  end
  initial begin
    repeat (3) @(posedge clk);
    nrst <= 1; wt <= 1;
    wait_run;
    rd(REG_CSR_ADDR, 32'h0, 32'hFFFF_FFFF);
    bus(1, REG_CSR_ADDR, 32'hF1);
    rd(REG_CSR_ADDR, 32'hC0, 32'hFF);
    rd(4'hF, 32'h0, 32'hFFFF_FFFF);
    lvl <= 3'h1; repeat (6) @(posedge clk);
    rd(REG_CSR_ADDR, 32'hE0, 32'hFF);
    rd(REG_IRQ_ADDR, 32'h1, 32'h1);
    bus(1, REG_CTRL_ADDR, 32'h0);
    check("irq", irq, 1);
    check("wake", wake, 1);
    bus(1, REG_CTRL_ADDR, 32'h1);
    check("irq", irq, 0);
    bus(1, REG_CTRL_ADDR, 32'h2);
    rd(REG_IRQ_ADDR, 32'h0, 32'h1);
    lvl <= 3'h0; repeat (6) @(posedge clk);
    rd(REG_IRQ_ADDR, 32'h1, 32'h1);
    ent <= 1; @(posedge clk); ent <= 0; @(posedge clk);
    rd(REG_IRQ_ADDR, 32'h0, 32'h1);
    bus(1, REG_CSR_ADDR, 32'h0); lvl <= 3'h2; repeat (6) @(posedge clk);
    bus(1, REG_CSR_ADDR, 32'h40);
    rd(REG_IRQ_ADDR, 32'h1, 32'h1);
    halt <= 1; bus(1, REG_CSR_ADDR, 32'h80);
    rd(REG_CSR_ADDR, 32'h60, 32'hE0);
    check("wake", wake, 0);
    halt <= 0; lvl <= 3'h0;
    for (int i = 0; i < 4; i++) begin
      r = $random(seed);
      bus(1, REG_CSR_ADDR, {24'h0, r[7:6], 6'h0});
      rd(REG_CSR_ADDR, {24'h0, r[7:6], 6'h0}, 32'hC0);
    end
    dog <= 1; @(posedge clk); dog <= 0; repeat (3) @(posedge clk);
    n = 0;
    while (oe === 1'b1 && n < 9000) begin @(posedge clk); n++; end
    check("pulse_len", 32'(n >= RST_PULSE_CYC - 3), 1);
    wait_run;
    rd(REG_CSR_ADDR, 32'h01, 32'h11);
    lvl <= 3'h4; repeat (8) @(posedge clk);
    check("pin_drive", oe, 1);
    lvl <= 3'h0; wait_run;
    rd(REG_CSR_ADDR, 32'h10, 32'h11);
    xl <= 1; repeat (5) @(posedge clk); xl <= 0; wait_run;
    rd(REG_CSR_ADDR, 32'h10, 32'h11);
    bus(1, REG_CSR_ADDR, 32'h0);
    rd(REG_CSR_ADDR, 32'h0, 32'h11);
    repeat (2) @(posedge clk);
    end_of_test;
  end
  // watchdog: the whole sequence needs well under 20k cycles
  initial begin
    #300us;
    mismatches++;
    end_of_test;
  end
endmodule
